// File: hdl/sacc_consts.vh
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
// Register byte offsets on the bus.
`define SACC_OFS_CONTROL 8'h00
`define SACC_OFS_CLKSEL 8'h04
`define SACC_OFS_RES_HIGH 8'h08
`define SACC_OFS_RES_LOW 8'h0C
`define SACC_OFS_FLAG 8'h10
`define SACC_OFS_IRQ_EN 8'h14
`define SACC_OFS_STATUS 8'h18
// Field positions in the conversion control register.
`define SACC_BIT_ENABLE 0
`define SACC_BIT_GO 1
`define SACC_CHS_LSB 2
`define SACC_CHS_MSB 5
`define SACC_BIT_REF 6
`define SACC_BIT_FORMAT 7
// Field positions in the clock select register.
`define SACC_CS_LSB 4
`define SACC_CS_MSB 6
`define SACC_CLKSEL_MASK 8'h70
// Reset values.
`define SACC_RST_CONTROL 8'h00
`define SACC_RST_CLKSEL 8'h00
`define SACC_RST_RESULT 8'h00
// Timing counts in conversion-clock periods and pclk cycles per instruction cycle.
`define SACC_CONV_TADS 4'd11
`define SACC_ABORT_TADS 2'd2
`define SACC_INSTR_CLKS 8'd4
// Internal oscillator period in ns and its length in pclk cycles.
`define SACC_PCLK_NS 25
`define SACC_FRC_NS 4000
`define SACC_FRC_CLKS (`SACC_FRC_NS / `SACC_PCLK_NS)
`endif

// File: hdl/sacc_conversion_control.v
// Operation
// - Done flag sets on every completed conversion.
// - Enabled completion wakes a sleeping core.
// - Format bit 7 picks right or left.
// - Left format: high 9..2, low 1..0 top.
// - Enable bit 0 powers the converter.
// - Writing start bit 1 begins conversion.
// - Completion clears busy, flags, loads result.
// - Clearing busy aborts, keeps old result.
// - Abort waits two periods, then acquires.
// - Reset restores registers, stops conversion.
// - Internal oscillator delays start one instruction.
// - Sleep completion without irq powers off.
// - Sleep with divided clock aborts, powers off.
// - Trigger sets busy and resets timer.
// - Channel codes map inputs and references.
// - Reference bit 6 picks pin or supply.
// - Clock select picks divider or oscillator.
// - Busy bit reads one while converting.
// - Unused clock select bits read zero.
// - Conversion lasts eleven conversion-clock periods.
// - Right format: high 9..8, low 7..0.
`timescale 1ns/1ps
`include "sacc_consts.vh"
module sacc_conversion_control #(
    parameter FRC_CLKS = `SACC_FRC_CLKS
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Core sleep state and wake request.
    input wire core_sleep,
    output wire wake_request,
    output wire conversion_irq,
    // Capture/compare trigger and timer reset.
    input wire ccu_trigger,
    output wire timer_reset,
    // Analog front end control.
    input wire sar_compare,
    output wire converter_power,
    output wire acquire,
    output reg [9:0] sar_trial,
    output reg [3:0] channel_select,
    output reg reference_select
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_DELAY = 2'd1;
    localparam ST_CONV = 2'd2;
    localparam ST_ABORT = 2'd3;
    localparam [7:0] RST_CLKSEL = `SACC_RST_CLKSEL;

    reg [7:0] control;
    reg [2:0] clock_divider_select;
    reg [7:0] result_high_byte;
    reg [7:0] result_low_byte;
    reg conversion_done_flag;
    reg conversion_irq_enable;
    reg powered_down;
    reg [1:0] state;
    reg [7:0] div_cnt;
    reg [7:0] delay_cnt;
    reg [3:0] tad_cnt;
    reg [3:0] bit_idx;
    wire setup;
    wire wr;
    wire use_frc;
    wire tad_tick;
    wire busy;
    wire sw_start;
    wire sw_abort;
    wire hw_start;
    wire start_req;
    wire done;
    wire sleep_abort;
    wire [9:0] final_result;
    reg [31:0] next_rdata;
    reg addr_ok;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Division ratio for a clock select code, less one.
    function [7:0] div_limit;
        input [2:0] code;
        input [7:0] frc;
        begin
            case (code)
                3'b000: div_limit = 8'h01;
                3'b100: div_limit = 8'h03;
                3'b001: div_limit = 8'h07;
                3'b101: div_limit = 8'h0F;
                3'b010: div_limit = 8'h1F;
                3'b110: div_limit = 8'h3F;
                default: div_limit = frc - 8'h01;
            endcase
        end
    endfunction

    // Place a 10-bit result into its high and low bytes.
    function [15:0] format_result;
        input right;
        input [9:0] res;
        begin
            if (right) begin
                format_result = {6'b00_0000, res[9:8], res[7:0]};
            end else begin
                format_result = {res[9:2], res[1:0], 6'b00_0000};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // The slave never waits, so every access ends in one cycle.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;

    // Address check for the mapped words.
    always @* begin
        addr_ok = 1'b0;
        if (paddr == `SACC_OFS_CONTROL) begin
            addr_ok = 1'b1;
        end else if (paddr == `SACC_OFS_CLKSEL) begin
            addr_ok = 1'b1;
        end else if (paddr == `SACC_OFS_RES_HIGH) begin
            addr_ok = 1'b1;
        end else if (paddr == `SACC_OFS_RES_LOW) begin
            addr_ok = 1'b1;
        end else if (paddr == `SACC_OFS_FLAG) begin
            addr_ok = 1'b1;
        end else if (paddr == `SACC_OFS_IRQ_EN) begin
            addr_ok = 1'b1;
        end else if (paddr == `SACC_OFS_STATUS) begin
            addr_ok = 1'b1;
        end
    end

    // Read data is latched in the setup phase so it is a flop output.
    always @* begin
        next_rdata = 32'h0000_0000;
        if (paddr == `SACC_OFS_CONTROL) begin
            next_rdata[7:0] = control;
        end else if (paddr == `SACC_OFS_CLKSEL) begin
            next_rdata[`SACC_CS_MSB:`SACC_CS_LSB] = clock_divider_select;
        end else if (paddr == `SACC_OFS_RES_HIGH) begin
            next_rdata[7:0] = result_high_byte;
        end else if (paddr == `SACC_OFS_RES_LOW) begin
            next_rdata[7:0] = result_low_byte;
        end else if (paddr == `SACC_OFS_FLAG) begin
            next_rdata[0] = conversion_done_flag;
        end else if (paddr == `SACC_OFS_IRQ_EN) begin
            next_rdata[0] = conversion_irq_enable;
        end else if (paddr == `SACC_OFS_STATUS) begin
            next_rdata[1:0] = state;
            next_rdata[2] = converter_power;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Control decisions
    // ------------------------------------------------------------
    assign busy = control[`SACC_BIT_GO];
    assign use_frc = (clock_divider_select[1:0] == 2'b11);
    // A start needs the converter already on; a write that enables and
    // starts at once only enables, which matches safe software use.
    assign sw_start = wr && paddr == `SACC_OFS_CONTROL && !busy &&
                      pwdata[`SACC_BIT_GO] && control[`SACC_BIT_ENABLE];
    assign sw_abort = wr && paddr == `SACC_OFS_CONTROL && busy &&
                      !pwdata[`SACC_BIT_GO];
    assign hw_start = ccu_trigger && !busy && control[`SACC_BIT_ENABLE] &&
                      state == ST_IDLE;
    assign timer_reset = hw_start;
    assign start_req = (sw_start && state == ST_IDLE) || hw_start;
    // Without the internal oscillator the converter cannot run in sleep.
    assign sleep_abort = core_sleep && !use_frc && busy;
    assign done = state == ST_CONV && tad_tick &&
                  tad_cnt == `SACC_CONV_TADS - 4'd1;
    assign final_result = sar_compare ? sar_trial :
                          (sar_trial & ~(10'd1 << bit_idx));
    assign converter_power = control[`SACC_BIT_ENABLE] & ~powered_down;
    assign acquire = converter_power && state == ST_IDLE;
    assign wake_request = core_sleep & conversion_done_flag &
                          conversion_irq_enable;
    assign conversion_irq = conversion_done_flag & conversion_irq_enable;

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------

    // One pulse per conversion-clock period; the oscillator option is a
    // divider too, since everything runs on pclk and nothing crosses.
    assign tad_tick = div_cnt == div_limit(clock_divider_select,
                                           FRC_CLKS[7:0]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 8'h00;
        end else if (state == ST_IDLE || state == ST_DELAY || tad_tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------

    // Control register; hardware owns the busy bit while converting.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= `SACC_RST_CONTROL;
        end else begin
            if (wr && paddr == `SACC_OFS_CONTROL) begin
                control[7:2] <= pwdata[7:2];
                control[`SACC_BIT_ENABLE] <= pwdata[`SACC_BIT_ENABLE];
            end
            if (start_req) begin
                control[`SACC_BIT_GO] <= 1'b1;
            end else if (sw_abort || sleep_abort || done) begin
                control[`SACC_BIT_GO] <= 1'b0;
            end else if (wr && paddr == `SACC_OFS_CONTROL &&
                         !pwdata[`SACC_BIT_ENABLE]) begin
                control[`SACC_BIT_GO] <= 1'b0;
            end
        end
    end

    // Selects presented to the analog side.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_select <= 4'h0;
            reference_select <= 1'b0;
        end else begin
            // Codes 1100 and 1101 pick the two references; 111x reserved.
            channel_select <= control[`SACC_CHS_MSB:`SACC_CHS_LSB];
            reference_select <= control[`SACC_BIT_REF];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_divider_select <= RST_CLKSEL[`SACC_CS_MSB:`SACC_CS_LSB];
            conversion_irq_enable <= 1'b0;
        end else begin
            if (wr && paddr == `SACC_OFS_CLKSEL) begin
                clock_divider_select <= pwdata[`SACC_CS_MSB:`SACC_CS_LSB];
            end
            if (wr && paddr == `SACC_OFS_IRQ_EN) begin
                conversion_irq_enable <= pwdata[0];
            end
        end
    end

    // Done flag: hardware set beats a software clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_done_flag <= 1'b0;
        end else if (done) begin
            conversion_done_flag <= 1'b1;
        end else if (wr && paddr == `SACC_OFS_FLAG && !pwdata[0]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // Result bytes: both load in one edge so no torn pair is seen.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_byte <= `SACC_RST_RESULT;
            result_low_byte <= `SACC_RST_RESULT;
        end else if (done) begin
            {result_high_byte, result_low_byte} <= format_result(
                control[`SACC_BIT_FORMAT], final_result);
        end else begin
            if (wr && paddr == `SACC_OFS_RES_HIGH) begin
                result_high_byte <= pwdata[7:0];
            end
            if (wr && paddr == `SACC_OFS_RES_LOW) begin
                result_low_byte <= pwdata[7:0];
            end
        end
    end

    // Power-down in sleep keeps the enable bit set; waking restores it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down <= 1'b0;
        end else if (!core_sleep) begin
            powered_down <= 1'b0;
        end else if (sleep_abort) begin
            powered_down <= 1'b1;
        end else if (done && !conversion_irq_enable) begin
            powered_down <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------

    // Busy bit cleared by any means ends the sequence; an abort then
    // holds off acquisition for two conversion-clock periods.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            delay_cnt <= 8'h00;
            tad_cnt <= 4'h0;
            bit_idx <= 4'h9;
            sar_trial <= 10'h000;
        end else begin
            case (state)
                ST_IDLE: begin
                    tad_cnt <= 4'h0;
                    delay_cnt <= 8'h00;
                    if (start_req) begin
                        state <= use_frc ? ST_DELAY : ST_CONV;
                    end
                end
                ST_DELAY: begin
                    if (sw_abort || !control[`SACC_BIT_ENABLE]) begin
                        state <= ST_ABORT;
                    end else if (delay_cnt == `SACC_INSTR_CLKS - 8'h01) begin
                        state <= ST_CONV;
                    end else begin
                        delay_cnt <= delay_cnt + 8'h01;
                    end
                end
                ST_CONV: begin
                    if (sw_abort || sleep_abort ||
                        !control[`SACC_BIT_ENABLE]) begin
                        state <= ST_ABORT;
                        tad_cnt <= 4'h0;
                    end else if (done) begin
                        state <= ST_IDLE;
                    end else if (tad_tick) begin
                        tad_cnt <= tad_cnt + 4'h1;
                        if (tad_cnt == 4'h0) begin
                            sar_trial <= 10'h200;
                            bit_idx <= 4'h9;
                        end else begin
                            sar_trial <= (final_result |
                                          (10'h200 >> (4'h9 - bit_idx + 4'h1)));
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                ST_ABORT: begin
                    if (tad_tick) begin
                        if (tad_cnt == {2'b00, `SACC_ABORT_TADS} - 4'h1) begin
                            state <= ST_IDLE;
                        end else begin
                            tad_cnt <= tad_cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: verif/sacc_conversion_control_assertions.sv
`timescale 1ns/1ps
`include "sacc_consts.vh"
module sacc_assertions (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // Core, trigger and front end.
    input wire core_sleep,
    input wire wake_request,
    input wire conversion_irq,
    input wire ccu_trigger,
    input wire timer_reset,
    input wire converter_power,
    input wire acquire,
    input wire [3:0] channel_select,
    input wire reference_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access-phase decodes shared by the properties below.
    wire wr_acc = psel && penable && pwrite;
    wire rd_acc = psel && penable && !pwrite;
    wire ctl_wr = wr_acc && (paddr == `SACC_OFS_CONTROL);
    chk_timer_cause: assert property (timer_reset |-> ccu_trigger)
        else $error("Timer reset without a trigger.");
    chk_wake_cause: assert property
        (wake_request |-> core_sleep && conversion_irq)
        else $error("Wake request without a pending interrupt.");
    // Only a flag or enable write may drop the interrupt.
    chk_flag_sticky: assert property (conversion_irq && !(wr_acc &&
        (paddr == `SACC_OFS_FLAG || paddr == `SACC_OFS_IRQ_EN))
        |=> conversion_irq) else $error("Done flag cleared by itself.");
    chk_power_off: assert property (ctl_wr && !pwdata[0]
        |=> !converter_power) else $error("Converter powered after disable.");
    chk_acquire_power: assert property (acquire |-> converter_power)
        else $error("Acquiring while unpowered.");
    chk_channel_copy: assert property (ctl_wr |-> ##2
        channel_select == $past(pwdata[5:2], 2))
        else $error("Channel select does not follow control.");
    chk_ref_copy: assert property (ctl_wr |-> ##2
        reference_select == $past(pwdata[6], 2))
        else $error("Reference select does not follow control.");
    chk_clksel_zero: assert property
        (rd_acc && paddr == `SACC_OFS_CLKSEL
        |-> prdata[7] == 1'b0 && prdata[3:0] == 4'h0)
        else $error("Unused clock select bits read nonzero.");
    // Main scenarios reached.
    cov_wake: cover property (wake_request);
    cov_irq: cover property ($rose(conversion_irq));
    cov_trigger: cover property (timer_reset);
endmodule
bind sacc_conversion_control sacc_assertions i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .core_sleep(core_sleep), .wake_request(wake_request),
    .conversion_irq(conversion_irq), .ccu_trigger(ccu_trigger),
    .timer_reset(timer_reset), .converter_power(converter_power),
    .acquire(acquire), .channel_select(channel_select),
    .reference_select(reference_select));

// File: verif/sacc_core_model.sv
`timescale 1ns/1ps
module sacc_core_model (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Sleep control.
    input wire sleep_cmd,
    input wire wake_cmd,
    input wire wake_request,
    output reg core_sleep,
    // Comparator.
    input wire [9:0] level,
    input wire [9:0] sar_trial,
    output wire sar_compare
);
    // Keeping a trial bit only while the trial does not exceed the level
    // makes a correct search end exactly on the level.
    assign sar_compare = (sar_trial <= level);
    // The core sleeps on command and only a wake event brings it back.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sleep <= 1'b0;
        end else if (wake_request || wake_cmd) begin
            core_sleep <= 1'b0;
        end else if (sleep_cmd) begin
            core_sleep <= 1'b1;
        end
    end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
`include "sacc_consts.vh"
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic ccu_trigger = 0, sleep_cmd = 0, wake_cmd = 0, err;
    logic [9:0] level = 0, sar_trial;
    logic [3:0] channel_select;
    wire pready, pslverr, wake_request, conversion_irq, timer_reset;
    wire sar_compare, converter_power, acquire, reference_select, core_sleep;
    int failures = 0, checks_done = 0, cycles = 0, n;
    always #12.5 pclk = ~pclk;
    sacc_conversion_control #(.FRC_CLKS(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .core_sleep(core_sleep),
        .wake_request(wake_request), .conversion_irq(conversion_irq),
        .ccu_trigger(ccu_trigger), .timer_reset(timer_reset),
        .sar_compare(sar_compare), .converter_power(converter_power),
        .acquire(acquire), .sar_trial(sar_trial),
        .channel_select(channel_select), .reference_select(reference_select));
    sacc_core_model i_core (.pclk(pclk), .presetn(presetn),
        .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd),
        .wake_request(wake_request), .core_sleep(core_sleep),
        .level(level), .sar_trial(sar_trial), .sar_compare(sar_compare));
    task results;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // A hang ends the run through the same report.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            results;
        end
    end
    task check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    // APB transfer; one idle edge after it keeps drivers single-assigned.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdr(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    task wait_done;
        n = 0;
        do begin rdr(`SACC_OFS_CONTROL); n++; end while (rd[1] && n < 300);
        check(rd[1] === 1'b0, "conversion never finished");
    endtask
    task sleep_now;
        sleep_cmd <= 1'b1;
        @(posedge pclk);
        sleep_cmd <= 1'b0;
        @(posedge pclk);
    endtask
    task t_regs;
        rdr(`SACC_OFS_CONTROL);
        check(rd[7:0] === 8'h00, "control reset value");
        wr(`SACC_OFS_CLKSEL, 32'h0000_00ff);
        rdr(`SACC_OFS_CLKSEL);
        check(rd[7:0] === 8'h70, "clock select read back");
        rdr(8'h1c);
        check(err === 1'b1 && rd === 32'h0, "unmapped read");
        wr(`SACC_OFS_CLKSEL, 32'h0);
        for (int i = 0; i < 16; i++) begin
            wr(`SACC_OFS_CONTROL, i << 2);
            @(posedge pclk);
            check(channel_select === i[3:0], "channel copy");
            check(converter_power === 1'b0, "disabled power");
        end
    endtask
    // Enable first, wait for acquisition, then start and check the result.
    task t_convert(input logic [7:0] ctl, input logic [9:0] lv);
        logic [7:0] hi;
        level <= lv;
        wr(`SACC_OFS_CONTROL, {24'h0, ctl});
        repeat (8) @(posedge pclk);
        wr(`SACC_OFS_CONTROL, {24'h0, ctl | 8'h02});
        wait_done;
        rdr(`SACC_OFS_FLAG);
        check(rd[0] === 1'b1, "flag after completion");
        rdr(`SACC_OFS_RES_HIGH);
        hi = rd[7:0];
        rdr(`SACC_OFS_RES_LOW);
        if (ctl[7]) begin
            check(hi === {6'h0, lv[9:8]}, "right high byte");
            check(rd[7:0] === lv[7:0], "right low byte");
        end else begin
            check(hi === lv[9:2], "left high byte");
            check(rd[7:6] === lv[1:0], "left low byte");
        end
        check(reference_select === ctl[6], "reference copy");
        wr(`SACC_OFS_FLAG, 32'h0);
        rdr(`SACC_OFS_FLAG);
        check(rd[0] === 1'b0, "flag cleared by software");
    endtask
    task t_abort;
        level <= 10'h0ff;
        wr(`SACC_OFS_CONTROL, 32'h0000_0083);
        repeat (4) @(posedge pclk);
        wr(`SACC_OFS_CONTROL, 32'h0000_0081);
        check(acquire === 1'b0, "acquire before two periods");
        n = 0;
        while (acquire !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
        check(n <= 8, "acquire after abort wait");
        rdr(`SACC_OFS_RES_HIGH);
        check(rd[7:0] === 8'h71, "high byte kept");
        rdr(`SACC_OFS_FLAG);
        check(rd[0] === 1'b0, "no flag on abort");
    endtask
    task t_trigger;
        ccu_trigger <= 1'b1;
        #1;
        check(timer_reset === 1'b1, "timer reset with trigger");
        @(posedge pclk);
        ccu_trigger <= 1'b0;
        rdr(`SACC_OFS_CONTROL);
        check(rd[1] === 1'b1, "trigger sets busy");
        wait_done;
        wr(`SACC_OFS_FLAG, 32'h0);
    endtask
    task t_sleep;
        wr(`SACC_OFS_CLKSEL, 32'h0000_0030);
        wr(`SACC_OFS_IRQ_EN, 32'h1);
        wr(`SACC_OFS_CONTROL, 32'h0000_0083);
        rdr(`SACC_OFS_STATUS);
        check(rd[1:0] === 2'd1, "oscillator start delay");
        sleep_now;
        n = 0;
        while (core_sleep !== 1'b0 && n < 300) begin @(posedge pclk); n++; end
        check(n < 300, "completion wakes core");
        wr(`SACC_OFS_FLAG, 32'h0);
        wr(`SACC_OFS_IRQ_EN, 32'h0);
        wr(`SACC_OFS_CONTROL, 32'h0000_0083);
        sleep_now;
        n = 0;
        while (converter_power !== 1'b0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        rdr(`SACC_OFS_CONTROL);
        check(rd[1:0] === 2'b01 && n < 300, "sleep completion off");
        wake_cmd <= 1'b1;
        @(posedge pclk);
        wake_cmd <= 1'b0;
        wr(`SACC_OFS_CLKSEL, 32'h0);
        wr(`SACC_OFS_CONTROL, 32'h0000_0083);
        sleep_now;
        @(posedge pclk);
        check(converter_power === 1'b0, "divided clock sleep off");
        rdr(`SACC_OFS_CONTROL);
        check(rd[1:0] === 2'b01, "sleep abort keeps enable");
        wake_cmd <= 1'b1;
        @(posedge pclk);
        wake_cmd <= 1'b0;
    endtask
    task t_reset;
        wr(`SACC_OFS_CONTROL, 32'h0000_0083);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        check(converter_power === 1'b0, "reset powers off");
        presetn <= 1'b1;
        @(posedge pclk);
        rdr(`SACC_OFS_CONTROL);
        check(rd[7:0] === 8'h00, "reset clears control");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_convert(8'h81, 10'h2b5);
        t_convert(8'h75, 10'h1c7);
        t_abort;
        t_trigger;
        t_sleep;
        t_reset;
        results;
    end
endmodule
